// ===== hw/rac_pkg.sv
// constants shared by the receiver adaptation control and meter bank
package rac_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam int unsigned    ADDR_W        = 10;
  localparam logic [7:0]     IDX_EQ_MODE   = 8'h3D;
  localparam logic [7:0]     IDX_PRED_MODE = 8'h3E;
  localparam logic [7:0]     IDX_PHASE_LO  = 8'h40;
  localparam logic [7:0]     IDX_PHASE_HI  = 8'h41;
  localparam logic [7:0]     IDX_CLIP      = 8'h42;
  localparam logic [7:0]     IDX_DC_LO     = 8'h44;
  localparam logic [7:0]     IDX_DC_HI     = 8'h45;
  localparam logic [7:0]     IDX_RXMAG_LO  = 8'h46;
  localparam logic [7:0]     IDX_RXMAG_HI  = 8'h47;
  localparam logic [7:0]     IDX_REMOTE_LO = 8'h48;
  localparam logic [7:0]     IDX_REMOTE_HI = 8'h49;
  localparam logic [7:0]     IDX_HIERR_LO  = 8'h4A;
  localparam logic [7:0]     IDX_HIERR_HI  = 8'h4B;

  // ==========================================================================
  // two-byte meter pairs, in slot order
  localparam int unsigned    NUM_PAIRS     = 5;
  localparam int unsigned    PAIR_PHASE    = 0;
  localparam int unsigned    PAIR_DC       = 1;
  localparam int unsigned    PAIR_RXMAG    = 2;
  localparam int unsigned    PAIR_REMOTE   = 3;
  localparam int unsigned    PAIR_HIERR    = 4;
  localparam logic [7:0]     PAIR_LO_IDX [NUM_PAIRS] =
    '{IDX_PHASE_LO, IDX_DC_LO, IDX_RXMAG_LO, IDX_REMOTE_LO, IDX_HIERR_LO};
  localparam logic [7:0]     PAIR_HI_IDX [NUM_PAIRS] =
    '{IDX_PHASE_HI, IDX_DC_HI, IDX_RXMAG_HI, IDX_REMOTE_HI, IDX_HIERR_HI};

  // ==========================================================================
  // mode register fields
  localparam int unsigned    MODE_W        = 4;
  localparam logic [3:0]     MODE_RESET    = 4'h0;
  localparam int unsigned    BIT_GAIN      = 0;
  localparam int unsigned    BIT_ADAPT     = 1;
  localparam int unsigned    BIT_ZERO_COEF = 2;
  localparam int unsigned    BIT_OLDEST    = 3;
  localparam int unsigned    BIT_ZERO_OUT  = 3;
  localparam logic [1:0]     GAIN_BASE_SHIFT  = 2'h0;
  localparam logic [1:0]     GAIN_BOOST_SHIFT = 2'h2;

  // ==========================================================================
  // accumulator geometry
  localparam int unsigned    PHASE_ACC_W   = 26;
  localparam int unsigned    PHASE_LSB     = 10;
  localparam int unsigned    WIDE_ACC_W    = 32;
  localparam int unsigned    WIDE_LSB      = 16;
  localparam int unsigned    HIERR_ACC_W   = 16;
  localparam int unsigned    METER_W       = 16;
  localparam int unsigned    CLIP_W        = 8;
  localparam logic [7:0]     CLIP_MAX      = 8'hFF;

endpackage : rac_pkg

// ===== hw/rac_meters.sv
// receiver adaptation control and performance meter register bank
// What this block does
// - with adaptation on, the oldest-tap bit limits equalizer updates to the oldest tap.
// - a clear bit zeroes a filter's taps continuously, but only while adaptation is on.
// - the adapt bit enables updates; clearing it freezes taps at their present values.
// - the boost bit makes that filter's adaptation gain four times the base gain.
// - the bypass bit forces predictor correction to zero while adaptation carries on.
// - the phase meter sums detector output in 26 bits and shows bits 25 down to 10.
// - at each interval end every meter register is loaded from its accumulator.
// - the clip counter counts ADC overflows per interval and saturates at 255.
// - the dc meter sums samples in 32 bits signed and shows bits 31 down to 16.
// - the signal meter sums sample magnitudes in 32 bits and shows the upper half.
// - the far-end meter sums echo-free magnitudes in 32 bits and shows the upper half.
// - the high-error meter counts symbols whose error magnitude exceeds the threshold.
module rac_meters #(
  parameter int unsigned SAMP_W = 16,
  parameter int unsigned PD_W   = 16,
  parameter int unsigned CORR_W = 16
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      pclken,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [rac_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      sym_valid,
  input  wire logic                      meter_end,
  input  wire logic signed [PD_W-1:0]    phase_err,
  input  wire logic                      adc_clip,
  input  wire logic signed [SAMP_W-1:0]  rx_sample,
  input  wire logic signed [SAMP_W-1:0]  remote_sample,
  input  wire logic signed [SAMP_W-1:0]  slicer_err,
  input  wire logic [SAMP_W-1:0]         err_threshold,
  input  wire logic signed [CORR_W-1:0]  pred_corr_in,
  output logic signed [CORR_W-1:0]       pred_corr_out,
  output logic                           eq_adapt_en,
  output logic                           eq_oldest_only,
  output logic                           eq_clear_coef,
  output logic      [1:0]                eq_gain_shift,
  output logic                           pred_adapt_en,
  output logic                           pred_clear_coef,
  output logic      [1:0]                pred_gain_shift,
  output logic                           pred_bypass
);
  import rac_pkg::*;

  // ==========================================================================
  // magnitude helper
  function automatic logic [SAMP_W:0] mag(input logic signed [SAMP_W-1:0] s);
    logic [SAMP_W:0] ext;
    ext = {s[SAMP_W-1], s};
    mag = ext[SAMP_W] ? (~ext + 1'b1) : ext;
  endfunction : mag

  logic [MODE_W-1:0]      eq_mode;
  logic [MODE_W-1:0]      pred_mode;
  logic [PHASE_ACC_W-1:0] phase_acc;
  logic [WIDE_ACC_W-1:0]  dc_acc;
  logic [WIDE_ACC_W-1:0]  rxmag_acc;
  logic [WIDE_ACC_W-1:0]  remote_acc;
  logic [HIERR_ACC_W-1:0] hierr_acc;
  logic [CLIP_W-1:0]      clip_acc;
  logic [CLIP_W-1:0]      clip_meter;
  logic [METER_W-1:0]     meter_q [NUM_PAIRS];
  logic [7:0]             hi_shadow [NUM_PAIRS];
  logic [SAMP_W:0]        rx_mag;
  logic [SAMP_W:0]        remote_mag;
  logic [SAMP_W:0]        err_mag;
  logic                   err_high;

  assign rx_mag     = mag(rx_sample);
  assign remote_mag = mag(remote_sample);
  assign err_mag    = mag(slicer_err);
  assign err_high   = err_mag > {1'b0, err_threshold};

  // ==========================================================================
  // apb decode
  logic [7:0]  idx;
  logic        aligned;
  logic        setup;
  logic        done;
  logic        wr_eq;
  logic        wr_pred;
  logic        rd_hit;
  logic [31:0] rd_val;

  assign idx     = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup   = psel & ~penable;
  assign done    = psel & penable & pready;
  assign wr_eq   = done & pwrite & aligned & (idx == IDX_EQ_MODE);
  assign wr_pred = done & pwrite & aligned & (idx == IDX_PRED_MODE);

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0;
    if (idx == IDX_EQ_MODE) begin
      rd_val = {28'h0, eq_mode};
    end else if (idx == IDX_PRED_MODE) begin
      rd_val = {28'h0, pred_mode};
    end else if (idx == IDX_CLIP) begin
      rd_val = {24'h0, clip_meter};
    end else begin
      rd_hit = 1'b0;
      for (int k = 0; k < NUM_PAIRS; k++) begin
        if (idx == PAIR_LO_IDX[k]) begin
          rd_hit = 1'b1;
          rd_val = {24'h0, meter_q[k][7:0]};
        end
        // high byte comes from the capture
        if (idx == PAIR_HI_IDX[k]) begin
          rd_hit = 1'b1;
          rd_val = {24'h0, hi_shadow[k]};
        end
      end
    end
    if (!aligned) begin
      rd_hit = 1'b0;
      rd_val = 32'h0;
    end
  end

  // no wait state: answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (pclken) begin
      pready <= setup;
      if (setup) begin
        prdata  <= pwrite ? 32'h0 : rd_val;
        pslverr <= ~rd_hit | (pwrite & (idx != IDX_EQ_MODE) & (idx != IDX_PRED_MODE));
      end
    end
  end

  // ==========================================================================
  // mode registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_mode   <= MODE_RESET;
      pred_mode <= MODE_RESET;
    end else if (pclken) begin
      if (wr_eq) begin
        eq_mode <= pwdata[MODE_W-1:0];
      end
      if (wr_pred) begin
        pred_mode <= pwdata[MODE_W-1:0];
      end
    end
  end

  // ==========================================================================
  // filter control outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_adapt_en     <= 1'b0;
      eq_oldest_only  <= 1'b0;
      eq_clear_coef   <= 1'b0;
      eq_gain_shift   <= GAIN_BASE_SHIFT;
      pred_adapt_en   <= 1'b0;
      pred_clear_coef <= 1'b0;
      pred_gain_shift <= GAIN_BASE_SHIFT;
      pred_bypass     <= 1'b0;
    end else if (pclken) begin
      eq_adapt_en     <= eq_mode[BIT_ADAPT];
      pred_adapt_en   <= pred_mode[BIT_ADAPT];
      eq_oldest_only  <= eq_mode[BIT_ADAPT] & eq_mode[BIT_OLDEST];
      eq_clear_coef   <= eq_mode[BIT_ADAPT] & eq_mode[BIT_ZERO_COEF];
      pred_clear_coef <= pred_mode[BIT_ADAPT] & pred_mode[BIT_ZERO_COEF];
      // boost is a shift of two
      eq_gain_shift   <= eq_mode[BIT_GAIN] ? GAIN_BOOST_SHIFT : GAIN_BASE_SHIFT;
      pred_gain_shift <= pred_mode[BIT_GAIN] ? GAIN_BOOST_SHIFT : GAIN_BASE_SHIFT;
      pred_bypass     <= pred_mode[BIT_ZERO_OUT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pred_corr_out <= '0;
    end else if (pclken) begin
      pred_corr_out <= pred_mode[BIT_ZERO_OUT] ? '0 : pred_corr_in;
    end
  end

  // ==========================================================================
  // accumulators
  // phase sum, restarts at interval end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_acc <= '0;
    end else if (pclken) begin
      if (meter_end) begin
        phase_acc <= sym_valid ? PHASE_ACC_W'(phase_err) : '0;
      end else if (sym_valid) begin
        phase_acc <= phase_acc + PHASE_ACC_W'(phase_err);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_acc     <= '0;
      rxmag_acc  <= '0;
      remote_acc <= '0;
    end else if (pclken) begin
      if (meter_end) begin
        dc_acc     <= sym_valid ? WIDE_ACC_W'(rx_sample) : '0;
        rxmag_acc  <= sym_valid ? WIDE_ACC_W'(rx_mag) : '0;
        remote_acc <= sym_valid ? WIDE_ACC_W'(remote_mag) : '0;
      end else if (sym_valid) begin
        dc_acc     <= dc_acc + WIDE_ACC_W'(rx_sample);
        rxmag_acc  <= rxmag_acc + WIDE_ACC_W'(rx_mag);
        remote_acc <= remote_acc + WIDE_ACC_W'(remote_mag);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hierr_acc <= '0;
    end else if (pclken) begin
      if (meter_end) begin
        hierr_acc <= HIERR_ACC_W'(sym_valid & err_high);
      end else if (sym_valid & err_high) begin
        hierr_acc <= hierr_acc + HIERR_ACC_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clip_acc <= '0;
    end else if (pclken) begin
      if (meter_end) begin
        clip_acc <= CLIP_W'(adc_clip);
      end else if (adc_clip && clip_acc != CLIP_MAX) begin
        clip_acc <= clip_acc + CLIP_W'(1);
      end
    end
  end

  // ==========================================================================
  // meter registers
  // load all meters at interval end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clip_meter <= '0;
      for (int k = 0; k < NUM_PAIRS; k++) begin
        meter_q[k] <= '0;
      end
    end else if (pclken && meter_end) begin
      clip_meter           <= clip_acc;
      meter_q[PAIR_PHASE]  <= phase_acc[PHASE_ACC_W-1:PHASE_LSB];
      meter_q[PAIR_DC]     <= dc_acc[WIDE_ACC_W-1:WIDE_LSB];
      meter_q[PAIR_RXMAG]  <= rxmag_acc[WIDE_ACC_W-1:WIDE_LSB];
      meter_q[PAIR_REMOTE] <= remote_acc[WIDE_ACC_W-1:WIDE_LSB];
      meter_q[PAIR_HIERR]  <= hierr_acc;
    end
  end

  // ==========================================================================
  // high byte capture per pair
  for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_shadow
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hi_shadow[g] <= 8'h00;
      end else if (pclken && setup && !pwrite && aligned && idx == PAIR_LO_IDX[g]) begin
        hi_shadow[g] <= meter_q[g][15:8];
      end
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_oldest_needs_adapt: assert property (eq_oldest_only |-> eq_adapt_en)
    else $error("oldest-tap mode active without adaptation");

  chk_clear_needs_adapt: assert property (
    (eq_clear_coef |-> eq_adapt_en) and (pred_clear_coef |-> pred_adapt_en))
    else $error("coefficient clear active without adaptation");

  chk_adapt_freeze: assert property (
    (pclken && wr_eq && !pwdata[BIT_ADAPT]) ##1 pclken
      |=> !eq_adapt_en && !eq_clear_coef)
    else $error("equalizer not frozen after adapt cleared");

  chk_pred_freeze: assert property (
    (pclken && wr_pred && !pwdata[BIT_ADAPT]) ##1 pclken
      |=> !pred_adapt_en && !pred_clear_coef)
    else $error("predictor not frozen after adapt cleared");

  chk_gain_boost: assert property (
    (pclken && wr_pred && pwdata[BIT_GAIN]) ##1 pclken
      |=> pred_gain_shift == GAIN_BOOST_SHIFT)
    else $error("predictor gain boost not applied");

  chk_bypass_zero: assert property (
    pclken && pred_mode[BIT_ZERO_OUT] |=> pred_corr_out == '0)
    else $error("predictor correction not zeroed in bypass");

  chk_phase_slice: assert property (
    pclken && meter_end |=> meter_q[PAIR_PHASE] == $past(phase_acc[25:10]))
    else $error("phase meter loaded with wrong slice");

  chk_meter_load: assert property (
    pclken && meter_end |=> clip_meter == $past(clip_acc))
    else $error("clip meter not loaded at interval end");

  chk_clip_count: assert property (
    pclken && !meter_end && adc_clip && clip_acc != CLIP_MAX
      |=> clip_acc == $past(clip_acc) + 8'h01)
    else $error("clip event not counted");

  chk_clip_saturate: assert property (
    pclken && !meter_end && clip_acc == CLIP_MAX |=> clip_acc == CLIP_MAX)
    else $error("clip counter wrapped past maximum");

  chk_dc_slice: assert property (
    pclken && meter_end |=> meter_q[PAIR_DC] == $past(dc_acc[31:16]))
    else $error("dc meter loaded with wrong slice");

  chk_mag_slices: assert property (
    pclken && meter_end |=> meter_q[PAIR_RXMAG] == $past(rxmag_acc[31:16]))
    else $error("signal meter loaded with wrong slice");

  chk_remote_slice: assert property (
    pclken && meter_end |=> meter_q[PAIR_REMOTE] == $past(remote_acc[31:16]))
    else $error("far-end meter loaded with wrong slice");

  chk_hierr_count: assert property (
    pclken && sym_valid && !meter_end && err_high
      |=> hierr_acc == $past(hierr_acc) + 16'h0001)
    else $error("high-error symbol not counted");

  chk_shadow_capture: assert property (
    pclken && setup && !pwrite && aligned && idx == IDX_HIERR_LO
      |=> hi_shadow[PAIR_HIERR] == $past(meter_q[PAIR_HIERR][15:8]))
    else $error("high byte not captured on low-byte read");

  chk_acc_restart: assert property (
    pclken && meter_end && !sym_valid |=> phase_acc == '0 && hierr_acc == '0)
    else $error("accumulator did not restart at interval end");

  cov_pair_read: cover property (done && !pwrite && idx == IDX_HIERR_LO
                                 ##[1:4] done && !pwrite && idx == IDX_HIERR_HI);
  cov_clip_full: cover property (pclken && meter_end && clip_acc == CLIP_MAX);
  cov_oldest:    cover property (eq_oldest_only && eq_gain_shift == GAIN_BOOST_SHIFT);
  cov_bypass:    cover property (pred_bypass && pred_adapt_en);

endmodule : rac_meters

// ===== verif/rac_apb_host.sv
// apb host model issuing register transfers to the meter bank
module rac_apb_host (
  input  wire logic                       pclk,
  output logic                            psel,
  output logic                            penable,
  output logic                            pwrite,
  output logic [rac_pkg::ADDR_W-1:0]      paddr,
  output logic [31:0]                     pwdata,
  input  wire logic [31:0]                prdata,
  input  wire logic                       pready,
  input  wire logic                       pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  import rac_pkg::*;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
  end

  // ==========================================================================
  // one transfer: setup, access held until pready, then release
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~addr;
    pwdata  <= ~wd;
  endtask : xfer

  task automatic rd_pair(input logic [7:0] lo_idx, output logic [31:0] lo, output logic [31:0] hi);
    logic e;
    xfer(1'b0, {lo_idx, 2'b00}, '0, lo, e);
    xfer(1'b0, {lo_idx + 8'h01, 2'b00}, '0, hi, e);
  endtask : rd_pair
endmodule : rac_apb_host

// ===== verif/tb_top.sv
// self-checking bench for the adaptation control and meter bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rac_pkg::*;

  logic                     pclk, presetn, pclken, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0]        paddr;
  logic [31:0]              pwdata, prdata, rd, rd2, old;
  logic                     sym_valid, meter_end, adc_clip, err, run, clip_all;
  logic signed [15:0]       phase_err, rx_sample, remote_sample, slicer_err;
  logic signed [15:0]       pred_corr_in, pred_corr_out;
  logic [15:0]              err_threshold;
  logic                     eq_adapt_en, eq_oldest_only, eq_clear_coef;
  logic                     pred_adapt_en, pred_clear_coef, pred_bypass;
  logic [1:0]               eq_gain_shift, pred_gain_shift;
  logic [3:0]               md;
  logic signed [25:0]       a_ph;
  logic signed [31:0]       a_dc;
  logic [31:0]              a_rx, a_rm;
  logic [15:0]              a_he;
  logic [7:0]               a_cl, e_cl;
  logic [15:0]              e_mtr [NUM_PAIRS];
  int                       num_errors, checks_done, seed;

  rac_meters dut (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sym_valid(sym_valid), .meter_end(meter_end),
    .phase_err(phase_err), .adc_clip(adc_clip), .rx_sample(rx_sample),
    .remote_sample(remote_sample), .slicer_err(slicer_err), .err_threshold(err_threshold),
    .pred_corr_in(pred_corr_in), .pred_corr_out(pred_corr_out), .eq_adapt_en(eq_adapt_en),
    .eq_oldest_only(eq_oldest_only), .eq_clear_coef(eq_clear_coef),
    .eq_gain_shift(eq_gain_shift), .pred_adapt_en(pred_adapt_en),
    .pred_clear_coef(pred_clear_coef), .pred_gain_shift(pred_gain_shift),
    .pred_bypass(pred_bypass));

  rac_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ==========================================================================
  // comparison, verdict, watchdog
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (30000) @(posedge pclk);
    num_errors++;
    test_done();
  end

  // ==========================================================================
  // random sample stimulus and reference accumulators
  function automatic logic [16:0] mag(input logic signed [15:0] v);
    return v[15] ? -{v[15], v} : {1'b0, v};
  endfunction : mag

  always @(posedge pclk) begin
    if (run) begin
      pclken        <= (($random(seed) & 7) != 0);
      sym_valid     <= 1'($random(seed));
      adc_clip      <= clip_all | 1'($random(seed));
      phase_err     <= 16'($random(seed));
      rx_sample     <= 16'($random(seed));
      remote_sample <= 16'($random(seed));
      slicer_err    <= 16'($random(seed));
      err_threshold <= 16'($random(seed) & 32'h7FFF);
    end else begin
      pclken    <= 1'b1;
      sym_valid <= 1'b0;
      adc_clip  <= 1'b0;
      {phase_err, rx_sample, remote_sample, slicer_err, err_threshold} <= '0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {a_ph, a_dc, a_rx, a_rm, a_he, a_cl, e_cl} <= '0;
      e_mtr <= '{default: '0};
    end else if (pclken) begin
      if (meter_end) begin
        e_mtr[PAIR_PHASE]  <= a_ph[25:10];
        e_mtr[PAIR_DC]     <= a_dc[31:16];
        e_mtr[PAIR_RXMAG]  <= a_rx[31:16];
        e_mtr[PAIR_REMOTE] <= a_rm[31:16];
        e_mtr[PAIR_HIERR]  <= a_he;
        e_cl               <= a_cl;
      end
      a_ph <= (meter_end ? '0 : a_ph) + (sym_valid ? 26'(phase_err) : '0);
      a_dc <= (meter_end ? '0 : a_dc) + (sym_valid ? 32'(rx_sample) : '0);
      a_rx <= (meter_end ? '0 : a_rx) + (sym_valid ? 32'(mag(rx_sample)) : '0);
      a_rm <= (meter_end ? '0 : a_rm) + (sym_valid ? 32'(mag(remote_sample)) : '0);
      a_he <= (meter_end ? '0 : a_he)
            + 16'(sym_valid && (mag(slicer_err) > {1'b0, err_threshold}));
      a_cl <= meter_end ? 8'(adc_clip) : (adc_clip && a_cl != CLIP_MAX) ? a_cl + 8'h01 : a_cl;
    end
  end

  // ==========================================================================
  // interval and readout helpers
  task automatic pulse_end();
    @(posedge pclk);
    meter_end <= 1'b1;
    @(posedge pclk);
    meter_end <= 1'b0;
  endtask : pulse_end

  task automatic interval(input int n);
    run <= 1'b1;
    repeat (n) @(posedge pclk);
    pulse_end();
    repeat (n) @(posedge pclk);
    run <= 1'b0;
    pulse_end();
    repeat (2) @(posedge pclk);
  endtask : interval

  task automatic read_all();
    logic [31:0] lo, hi;
    for (int p = 0; p < NUM_PAIRS; p++) begin
      host.rd_pair(PAIR_LO_IDX[p], lo, hi);
      check(lo, {24'h0, e_mtr[p][7:0]});
      check(hi, {24'h0, e_mtr[p][15:8]});
    end
    host.xfer(1'b0, {IDX_CLIP, 2'b00}, '0, lo, err);
    check(lo, {24'h0, e_cl});
  endtask : read_all

  // ==========================================================================
  // main sequence
  initial begin
    seed = 69;
    {num_errors, checks_done} = '0;
    {run, clip_all, presetn, meter_end, pred_corr_in} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    host.xfer(1'b0, {IDX_PHASE_HI, 2'b00}, '0, rd, err);
    check(rd, 32'h0);
    host.xfer(1'b1, {IDX_PHASE_LO, 2'b00}, '1, rd, err);
    check(32'(err), 32'h1);
    host.xfer(1'b0, 10'h10C, '0, rd, err);
    check({rd[30:0], err}, 32'h1);
    host.xfer(1'b1, {IDX_EQ_MODE, 2'b10}, 32'hF, rd, err);
    check(32'(err), 32'h1);
    host.xfer(1'b0, {IDX_EQ_MODE, 2'b00}, '0, rd, err);
    check(rd, 32'h0);
    for (int v = 0; v < 32; v++) begin
      md = v[3:0];
      host.xfer(1'b1, {v[4] ? IDX_PRED_MODE : IDX_EQ_MODE, 2'b00},
                {28'($random(seed)), md}, rd, err);
      pred_corr_in <= 16'($random(seed));
      repeat (2) @(posedge pclk);
      host.xfer(1'b0, {v[4] ? IDX_PRED_MODE : IDX_EQ_MODE, 2'b00}, '0, rd, err);
      check(rd, {28'h0, md});
      if (v[4]) begin
        check(32'({pred_adapt_en, pred_clear_coef, pred_gain_shift}), 32'({md[1], md[2] & md[1],
              md[0] ? GAIN_BOOST_SHIFT : GAIN_BASE_SHIFT}));
        check({15'h0, pred_bypass, pred_corr_out},
              {15'h0, md[3], md[3] ? 16'h0 : pred_corr_in});
      end else begin
        check(32'({eq_adapt_en, eq_oldest_only, eq_clear_coef, eq_gain_shift}), 32'({md[1],
              md[3] & md[1], md[2] & md[1],
              md[0] ? GAIN_BOOST_SHIFT : GAIN_BASE_SHIFT}));
      end
    end
    for (int k = 0; k < 3; k++) begin
      interval(100 + ($random(seed) & 127));
      read_all();
    end
    host.xfer(1'b0, {IDX_DC_LO, 2'b00}, '0, rd, err);
    old = {16'h0, e_mtr[PAIR_DC]};
    interval(60);
    host.xfer(1'b0, {IDX_DC_HI, 2'b00}, '0, rd2, err);
    check({rd[7:0], rd2[7:0]}, {old[7:0], old[15:8]});
    clip_all <= 1'b1;
    interval(400);
    read_all();
    test_done();
  end
endmodule : tb_top
